// *** hw/spmp_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the port.
// Assumes a 12-bit APB byte address and 32-bit data words.
`ifndef SPMP_CFG_SVH
`define SPMP_CFG_SVH

// Register byte offsets.
`define SPMP_OFF_CTRL 12'h000
`define SPMP_OFF_CSR 12'h004
`define SPMP_OFF_DATA 12'h008

// Bits of ctrl_reg.
`define SPMP_IRQEN 7
`define SPMP_PEN 6
`define SPMP_SPR2 5
`define SPMP_MASTER_SELECT 4
`define SPMP_CLK_POLARITY 3
`define SPMP_CLK_PHASE 2
`define SPMP_SPR1 1
`define SPMP_SPR0 0

// Bits of ctrl_status_reg.
`define SPMP_XFER_DONE_FLAG 7
`define SPMP_WRITE_CLASH_FLAG 6
`define SPMP_OVR 5
`define SPMP_MODE_FAULT_FLAG 4
`define SPMP_SOD 2
`define SPMP_SSM 1
`define SPMP_SSI 0

// Reset values.
`define SPMP_CTRL_RST 8'h00
`define SPMP_CFG_RST 3'h0

// Half periods of the master clock in pclk cycles, per rate code.
`define SPMP_HALF_DIV4 7'h02
`define SPMP_HALF_DIV8 7'h04
`define SPMP_HALF_DIV16 7'h08
`define SPMP_HALF_DIV32 7'h10
`define SPMP_HALF_DIV64 7'h20
`define SPMP_HALF_DIV128 7'h40

// Index of the last clock edge in one byte.
`define SPMP_LAST_EDGE 4'hF
`endif

// *** hw/spmp_pkg.sv ***
// Types shared by the serial port design.
// Assumes spmp_cfg.svh is on the include path.
package spmp_pkg;
  // Master engine state.
  typedef enum logic {SPMP_IDLE, SPMP_RUN} spmp_mst_e;
  // Byte carried on the serial link.
  typedef logic [7:0] spmp_byte_t;
endpackage

// *** hw/spmp_port.sv ***
// Byte-wide serial peripheral port, master or slave, with APB registers.
// Assumes pins arrive unsynchronised and the pad logic merges enables.
// Function
// - Master data write loads shifter, MSB first.
// - Completion sets done flag; gated interrupt.
// - Master done clear: status access, data read.
// - Slave done clear: status access, data access.
// - Data writes ignored while done, until status read.
// - Slave shifts on external clock, MSB first.
// - Polarity and phase pick the capture edge.
// - Select low as master sets mode fault.
// - Mode fault clears enable and master select.
// - Fault clear: status read, control write.
// - Fault blocks setting enable/master outside clearing.
// - Mode fault never set as slave.
// - Byte over pending done sets overrun.
// - Overrun keeps first byte, drops later ones.
// - Data write while busy discarded, sets clash.
// - Clash flag raises no interrupt.
// - Data write never clears clash flag.
// - Wait mode runs normally; events wake.
// - Halt freezes register writes; extra bytes overrun.
`timescale 1ns/1ps
`include "spmp_cfg.svh"

module spmp_port import spmp_pkg::*; (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side.
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic irq_req,
  output logic wake_req,
  // Serial pins.
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i
);

  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic sck_d;
  logic [7:0] ctrl_reg;
  logic [2:0] cfg_reg;
  logic xfer_done_flag_reg, write_clash_flag_reg, ovr_reg, mode_fault_flag_reg;
  logic xfer_done_flag_acc_reg, xfer_done_flag_rd_reg, write_clash_flag_rd_reg, mode_fault_flag_rd_reg;
  spmp_byte_t shift_reg;
  spmp_byte_t rx_reg;
  logic cap_reg, out_reg;
  logic [3:0] edge_reg;
  spmp_mst_e mst_reg;
  logic [6:0] div_reg;
  logic sck_lvl_reg;
  logic [31:0] prdata_reg;

  // Pin inputs pass two flops; reset shows a low clock, so no false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 4'h7;
      pin_s2 <= 4'h7;
    end else begin
      pin_s1 <= {sck_i, mosi_i, miso_i, ss_n_i};
      pin_s2 <= pin_s1;
    end
  end

  logic sck_s, mosi_s, miso_s, ss_s;
  assign sck_s = pin_s2[3];
  assign mosi_s = pin_s2[2];
  assign miso_s = pin_s2[1];
  assign ss_s = pin_s2[0];

  // Configuration fields.
  logic pen, master_select, clk_polarity, clk_phase, sod, ssm, ssi, ss_int;
  assign pen = ctrl_reg[`SPMP_PEN];
  assign master_select = ctrl_reg[`SPMP_MASTER_SELECT];
  assign clk_polarity = ctrl_reg[`SPMP_CLK_POLARITY];
  assign clk_phase = ctrl_reg[`SPMP_CLK_PHASE];
  assign sod = cfg_reg[`SPMP_SOD];
  assign ssm = cfg_reg[`SPMP_SSM];
  assign ssi = cfg_reg[`SPMP_SSI];
  // Internal select comes from the pin or from software.
  assign ss_int = ssm ? ssi : ss_s;

  // Bus decode; writes are frozen while the CPU is halted.
  logic acc, wr, rd, hit_ctrl, hit_csr, hit_dr;
  logic ctrl_wr, csr_wr, csr_rd, csr_acc, dr_wr, dr_rd;
  assign acc = psel & penable;
  assign wr = acc & pwrite & ~halt_mode;
  assign rd = acc & ~pwrite;
  assign hit_ctrl = paddr == `SPMP_OFF_CTRL;
  assign hit_csr = paddr == `SPMP_OFF_CSR;
  assign hit_dr = paddr == `SPMP_OFF_DATA;
  assign ctrl_wr = wr & hit_ctrl;
  assign csr_wr = wr & hit_csr;
  assign csr_rd = rd & hit_csr;
  assign csr_acc = csr_rd | csr_wr;
  assign dr_wr = wr & hit_dr;
  assign dr_rd = rd & hit_dr;

  // Zero wait states; unmapped addresses answer with an error.
  assign pready = acc;
  assign pslverr = acc & ~(hit_ctrl | hit_csr | hit_dr);
  assign prdata = prdata_reg;

  // Engine activity and transfer events.
  logic m_busy, s_busy, active, tick, s_edge, eng_edge;
  logic din, done, mfault, dr_block, dr_take, write_clash_flag_evt;
  spmp_byte_t rx_byte;
  assign m_busy = mst_reg == SPMP_RUN;
  // With phase 0 a selected slave counts as busy for the whole select.
  assign s_busy = (edge_reg != 4'h0) | (~clk_phase & ~ss_int);
  assign active = master_select ? m_busy : s_busy;
  assign s_edge = pen & ~master_select & ~ss_int & (sck_s != sck_d);
  // A halted master stops clocking; a slave keeps receiving.
  assign eng_edge = master_select ? (m_busy & tick & ~halt_mode) : s_edge;
  assign din = master_select ? miso_s : mosi_s;
  assign done = eng_edge & (edge_reg == `SPMP_LAST_EDGE);
  assign rx_byte = {shift_reg[6:0], clk_phase ? din : cap_reg};
  // A master driven low on its select is a fault; slaves never fault.
  assign mfault = pen & master_select & ~ss_int;
  assign dr_block = xfer_done_flag_reg & ~xfer_done_flag_rd_reg;
  assign dr_take = dr_wr & ~dr_block & ~active;
  assign write_clash_flag_evt = dr_wr & ~dr_block & active;

  // Half period for the selected master rate.
  logic [6:0] half;
  always_comb begin
    unique case ({ctrl_reg[`SPMP_SPR2], ctrl_reg[1:0]})
      3'h4: half = `SPMP_HALF_DIV4;
      3'h0: half = `SPMP_HALF_DIV8;
      3'h1: half = `SPMP_HALF_DIV16;
      3'h6: half = `SPMP_HALF_DIV32;
      3'h2: half = `SPMP_HALF_DIV64;
      3'h3: half = `SPMP_HALF_DIV128;
      default: half = `SPMP_HALF_DIV128;
    endcase
  end
  assign tick = div_reg == (half - 7'h01);

  // Rate divider; it restarts at every byte so edges stay even.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 7'h00;
    end else if (!m_busy || tick || halt_mode) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  // Delayed link clock for edge finding.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  // Control register; a fault overrides a same-cycle write of enable and master select.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SPMP_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= pwdata[7:0];
        if (mode_fault_flag_reg && !mode_fault_flag_rd_reg) begin
          ctrl_reg[`SPMP_PEN] <= pwdata[`SPMP_PEN] & pen;
          ctrl_reg[`SPMP_MASTER_SELECT] <= pwdata[`SPMP_MASTER_SELECT] & master_select;
        end
      end
      if (mfault) begin
        ctrl_reg[`SPMP_PEN] <= 1'b0;
        ctrl_reg[`SPMP_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  // Writable part of the status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `SPMP_CFG_RST;
    end else if (csr_wr) begin
      cfg_reg <= pwdata[2:0];
    end
  end

  // Master engine: runs from an accepted data write to the last edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_reg <= SPMP_IDLE;
    end else if (mfault || !pen || !master_select) begin
      mst_reg <= SPMP_IDLE;
    end else begin
      unique case (mst_reg)
        SPMP_IDLE: if (dr_take) mst_reg <= SPMP_RUN;
        SPMP_RUN: if (done) mst_reg <= SPMP_IDLE;
      endcase
    end
  end

  // Master clock level; sixteen toggles return it to idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_lvl_reg <= 1'b0;
    end else if (!m_busy) begin
      sck_lvl_reg <= 1'b0;
    end else if (eng_edge) begin
      sck_lvl_reg <= ~sck_lvl_reg;
    end
  end

  // Edge counter; a slave of either phase restarts on each deselect.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_reg <= 4'h0;
    end else if (mfault || !pen || (!master_select && ss_int) || dr_take) begin
      edge_reg <= 4'h0;
    end else if (eng_edge) begin
      edge_reg <= edge_reg + 4'h1;
    end
  end

  // Shifter. Even edges capture (phase 0) or drive (phase 1); odd
  // edges shift, so the capture edge follows polarity and phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
      cap_reg <= 1'b0;
      out_reg <= 1'b0;
    end else if (dr_take) begin
      shift_reg <= pwdata[7:0];
      out_reg <= pwdata[7];
    end else if (eng_edge) begin
      if (!edge_reg[0]) begin
        if (clk_phase) begin
          out_reg <= shift_reg[7];
        end else begin
          cap_reg <= din;
        end
      end else begin
        shift_reg <= rx_byte;
      end
    end
  end

  // Receive buffer holds the first byte after the flag was cleared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reg <= 8'h00;
    end else if (done && !xfer_done_flag_reg) begin
      rx_reg <= rx_byte;
    end
  end

  // Clearing steps; slaves may finish the sequence with a write.
  logic xfer_done_flag_clr, write_clash_flag_clr, mode_fault_flag_clr;
  assign xfer_done_flag_clr = xfer_done_flag_acc_reg & (dr_rd | (~master_select & dr_wr));
  assign write_clash_flag_clr = write_clash_flag_rd_reg & dr_rd;
  assign mode_fault_flag_clr = mode_fault_flag_rd_reg & ctrl_wr;

  // Sticky flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_done_flag_reg <= 1'b0;
      ovr_reg <= 1'b0;
      write_clash_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
    end else begin
      xfer_done_flag_reg <= done | (xfer_done_flag_reg & ~xfer_done_flag_clr);
      ovr_reg <= (done & xfer_done_flag_reg) | (ovr_reg & ~csr_rd);
      write_clash_flag_reg <= write_clash_flag_evt | (write_clash_flag_reg & ~write_clash_flag_clr);
      mode_fault_flag_reg <= mfault | (mode_fault_flag_reg & ~mode_fault_flag_clr);
    end
  end

  // First step of each clearing sequence, dropped once the flag falls.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_done_flag_acc_reg <= 1'b0;
      xfer_done_flag_rd_reg <= 1'b0;
      write_clash_flag_rd_reg <= 1'b0;
      mode_fault_flag_rd_reg <= 1'b0;
    end else begin
      xfer_done_flag_acc_reg <= xfer_done_flag_reg & ~xfer_done_flag_clr & (xfer_done_flag_acc_reg | csr_acc);
      xfer_done_flag_rd_reg <= xfer_done_flag_reg & ~xfer_done_flag_clr & (xfer_done_flag_rd_reg | csr_rd);
      write_clash_flag_rd_reg <= write_clash_flag_reg & ~write_clash_flag_clr & (write_clash_flag_rd_reg | csr_rd);
      mode_fault_flag_rd_reg <= mode_fault_flag_reg & ~mode_fault_flag_clr & (mode_fault_flag_rd_reg | csr_rd);
    end
  end

  // Read data is latched in the setup phase so it comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `SPMP_OFF_CTRL) begin
        prdata_reg <= {24'h000000, ctrl_reg};
      end else if (paddr == `SPMP_OFF_CSR) begin
        prdata_reg <= {24'h000000, xfer_done_flag_reg, write_clash_flag_reg, ovr_reg,
                       mode_fault_flag_reg, 1'b0, cfg_reg};
      end else if (paddr == `SPMP_OFF_DATA) begin
        prdata_reg <= {24'h000000, rx_reg};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Interrupt and wake; the clash flag takes no part in either.
  logic irq_src;
  assign irq_src = ctrl_reg[`SPMP_IRQEN] & (xfer_done_flag_reg | ovr_reg | mode_fault_flag_reg);
  assign irq_req = irq_src & ~cpu_irq_mask;
  // Halt exits only on completion; wait exits on completion, overrun or mode fault.
  assign wake_req = (wait_mode & irq_src) |
                    (halt_mode & ctrl_reg[`SPMP_IRQEN] & xfer_done_flag_reg);

  // Pin drivers, blocked while the port is disabled.
  assign sck_o = clk_polarity ^ sck_lvl_reg;
  assign sck_oe = pen & master_select;
  assign mosi_o = clk_phase ? out_reg : shift_reg[7];
  assign mosi_oe = pen & master_select & ~sod;
  assign miso_o = clk_phase ? out_reg : shift_reg[7];
  assign miso_oe = pen & ~master_select & ~sod & ~ss_int;
endmodule

// *** sim/spmp_props.sv ***
// Checker of the port's bus answers, request gating and pin enables.
// Assumes it is bound to spmp_port and that pclk is the only clock.
`timescale 1ns/1ps
module spmp_props (
  // Bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // CPU and pins.
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_i
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  // Access phase of a bus transfer.
  assign acc = psel && penable;
  a_zero_wait:
    assert property (acc |-> pready) else $error("no ready in access");
  a_bad_addr:
    assert property (acc && paddr > 12'h008 |-> pslverr &&
      (pwrite || prdata == 32'h0)) else $error("hole not refused");
  a_irq_gate:
    assert property (cpu_irq_mask |-> !irq_req) else $error("irq masked");
  a_wait_wake:
    assert property (wait_mode && irq_req |-> wake_req)
      else $error("no wake in wait");
  logic ssm_sh;
  // Shadow of the select source; under software select the pin is free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ssm_sh <= 1'b0;
    end else if (acc && pwrite && !halt_mode && paddr == 12'h004) begin
      ssm_sh <= pwdata[1];
    end
  end
  a_fault_drop:
    assert property (sck_oe && !ssm_sh && !ss_n_i |-> ##[1:6] !sck_oe)
      else $error("master kept pins after fault");
  a_oe_from_wr:
    assert property ($rose(sck_oe) |-> $past(acc && pwrite &&
      paddr == 12'h000)) else $error("enable rose without write");
  a_oe_pair:
    assert property (mosi_oe |-> sck_oe) else $error("data without clock");
  a_master_miso:
    assert property (sck_oe |-> !miso_oe) else $error("master drove miso");
  // Main scenarios.
  c_irq: cover property ($rose(irq_req));
  c_fault: cover property (sck_oe && !ss_n_i);
  c_hole: cover property (acc && pslverr);
endmodule
bind spmp_port spmp_props i_spmp_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_irq_mask,
  .wait_mode, .halt_mode, .irq_req, .wake_req, .sck_oe, .mosi_oe, .miso_oe,
  .ss_n_i);

// *** sim/spmp_peer.sv ***
// Far-side device: a mode 0 slave to the port, or a master of it.
// Assumes the bench resolves the shared wires and calls the tasks.
`timescale 1ns/1ps
module spmp_peer (
  // Timing and serial wires.
  input wire logic pclk,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_s,
  output logic miso,
  // Master role pins.
  output logic sck_m,
  output logic mosi_m,
  output logic ss_n_m,
  // Byte taken in the slave role.
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  // Idle: master role off, select high.
  initial begin
    sh = 8'h00;
    rx_byte = 8'h00;
    {sck_m, mosi_m, ss_n_m} = 3'h1;
  end
  // Top bit leads, so the first capture edge finds it.
  assign miso = sh[7];
  // Capture on rising; the inverted feedback keeps a stale line moving.
  always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
  always @(negedge sck) sh <= {sh[6:0], ~sh[7]};
  // Loads the answer of the slave role.
  task automatic arm(input logic [7:0] b);
    sh = b;
  endtask
  // Master role: select low over the byte, 160 ns clock, top bit first.
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    ss_n_m <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_m <= b[i];
      repeat (10) @(posedge pclk);
      sck_m <= 1'b1;
      r[i] = miso_s;
      repeat (10) @(posedge pclk);
      sck_m <= 1'b0;
    end
    repeat (10) @(posedge pclk);
    ss_n_m <= 1'b1;
    mosi_m <= ~b[0];
    // Keep the select high a while so back-to-back bytes see a gap.
    repeat (10) @(posedge pclk);
  endtask
endmodule

// *** sim/spmp_port_tb.sv ***
// Bench of the serial port: APB master, far-side peer and checks.
// Assumes spmp_cfg.svh on the include path and the peer compiled first.
`timescale 1ns/1ps
`include "spmp_cfg.svh"
module spmp_port_tb import spmp_pkg::*; ;
  localparam logic [11:0] off_ct = `SPMP_OFF_CTRL;
  localparam logic [11:0] off_cs = `SPMP_OFF_CSR;
  localparam logic [11:0] off_dt = `SPMP_OFF_DATA;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cpu_irq_mask, wait_mode, halt_mode, irq_req, wake_req, ss_drop;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic sck_m, mosi_m, ss_n_m, miso_p, sck_w, mosi_w, miso_w;
  spmp_byte_t q, r, rx_b;
  int n_fail = 0, tests_run = 0, cyc = 0;
  // Master bytes: sent by the port, answered by the peer.
  spmp_byte_t rows [3][2] = '{'{8'hA5, 8'h3C}, '{8'h01, 8'h80},
    '{8'hFF, 8'h00}};
  // Wire levels from every party's enable.
  assign sck_w = sck_oe ? sck_o : sck_m;
  assign mosi_w = mosi_oe ? mosi_o : mosi_m;
  assign miso_w = miso_oe ? miso_o : miso_p;
  spmp_port i_spmp_port (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_irq_mask, .wait_mode,
    .halt_mode, .irq_req, .wake_req, .sck_i(sck_w), .sck_o, .sck_oe,
    .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe,
    .ss_n_i(ss_n_m & ~ss_drop));
  spmp_peer i_spmp_peer (.pclk, .sck(sck_w), .mosi(mosi_w), .miso_s(miso_w),
    .miso(miso_p), .sck_m, .mosi_m, .ss_n_m, .rx_byte(rx_b));
  // Clock, and a ceiling well above the expected run.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input spmp_byte_t e, input spmp_byte_t g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // One transfer; read data and error flag land in q and err.
  task automatic apb(input logic w, input logic [11:0] a, input spmp_byte_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input spmp_byte_t d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string s, input logic [11:0] a,
    input spmp_byte_t m, input spmp_byte_t e);
    apb(1'b0, a, 8'h00);
    chk(s, e, q & m);
  endtask
  // A byte lasts 16 half periods of 4 cycles plus one, so 80 is ample.
  task automatic mxfer(input spmp_byte_t t, input spmp_byte_t p);
    i_spmp_peer.arm(p);
    wr(off_dt, t);
    repeat (80) @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, cpu_irq_mask, wait_mode, halt_mode,
      ss_drop} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl_rst", off_ct, 8'hFF, 8'h00);
    rdc("csr_rst", off_cs, 8'hFF, 8'h00);
    rdc("hole", 12'h00C, 8'hFF, 8'h00);
    chk("slverr", 8'h01, {7'h00, err});
    // Master at pclk/8, interrupts on, internal select held high.
    wait_mode <= 1'b1;
    wr(off_cs, 8'h03);
    wr(off_ct, 8'hD0);
    foreach (rows[i]) begin
      mxfer(rows[i][0], rows[i][1]);
      chk("peer_rx", rows[i][0], rx_b);
      chk("irq", 8'h01, {7'h00, irq_req});
      chk("wake", 8'h01, {7'h00, wake_req});
      rdc("csr_done", off_cs, 8'hF0, 8'h80);
      rdc("rx", off_dt, 8'hFF, rows[i][1]);
      rdc("csr_clr", off_cs, 8'hF0, 8'h00);
    end
    // Masked request, a blocked write, then an overrun.
    cpu_irq_mask <= 1'b1;
    mxfer(8'h6C, 8'h22);
    chk("irq_mask", 8'h00, {7'h00, irq_req});
    cpu_irq_mask <= 1'b0;
    mxfer(8'h12, 8'h00);
    chk("blocked", 8'h6C, rx_b);
    rdc("csr_pend", off_cs, 8'hF0, 8'h80);
    mxfer(8'h5A, 8'h44);
    chk("unblocked", 8'h5A, rx_b);
    rdc("ovr", off_cs, 8'hF0, 8'hA0);
    rdc("keep", off_dt, 8'hFF, 8'h22);
    rdc("ovr_clr", off_cs, 8'hF0, 8'h00);
    // A second data write in mid-byte is dropped and flagged.
    i_spmp_peer.arm(8'h00);
    wr(off_dt, 8'h96);
    wr(off_dt, 8'h33);
    repeat (80) @(posedge pclk);
    chk("clash_tx", 8'h96, rx_b);
    rdc("write_clash_flag", off_cs, 8'hF0, 8'hC0);
    rdc("rx_c", off_dt, 8'hFF, 8'h00);
    rdc("write_clash_flag_clr", off_cs, 8'hF0, 8'h00);
    // Select pulled low while master; restore needs the clearing steps.
    wr(off_cs, 8'h00);
    ss_drop <= 1'b1;
    repeat (8) @(posedge pclk);
    ss_drop <= 1'b0;
    chk("mode_fault_flag_irq", 8'h01, {7'h00, irq_req});
    rdc("ct_fault", off_ct, 8'hFF, 8'h80);
    wr(off_ct, 8'hD0);
    rdc("ct_hold", off_ct, 8'hFF, 8'h80);
    rdc("mode_fault_flag", off_cs, 8'hF0, 8'h10);
    wr(off_ct, 8'hD0);
    rdc("mode_fault_flag_clr", off_cs, 8'hF0, 8'h00);
    // Slave on the peer's clock; a data write ends the clear.
    wr(off_ct, 8'h00);
    wr(off_ct, 8'h40);
    wr(off_dt, 8'hC3);
    i_spmp_peer.xfer(8'h3C, r);
    chk("miso", 8'hC3, r);
    rdc("s_done", off_cs, 8'hF0, 8'h80);
    wr(off_dt, 8'h00);
    rdc("s_clr", off_cs, 8'hF0, 8'h00);
    rdc("s_rx", off_dt, 8'hFF, 8'h3C);
    // Halted slave: writes frozen, two bytes give an overrun and a wake.
    wr(off_ct, 8'hC0);
    halt_mode <= 1'b1;
    wr(off_ct, 8'h00);
    i_spmp_peer.xfer(8'h11, r);
    i_spmp_peer.xfer(8'h22, r);
    chk("halt_wake", 8'h01, {7'h00, wake_req});
    halt_mode <= 1'b0;
    rdc("halt_ct", off_ct, 8'hFF, 8'hC0);
    rdc("halt_ovr", off_cs, 8'hF0, 8'hA0);
    rdc("halt_rx", off_dt, 8'hFF, 8'h11);
    stop_test();
  end
endmodule
